// File: ssf_host_model.sv
// host-side model of the serial link
`timescale 1ns/1ps
module ssf_host_model
(
  // serial pins
  output logic sck,
  output logic ce_n,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  // ********************
  // link driver
  // ********************
  // 125 ns period, under the limit
  localparam realtime HALF = 62.5;
  logic idle_lvl = 1'b0;

  initial
  begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  task automatic set_mode(input logic m3);
    begin
      idle_lvl = m3;
      sck = m3;
      #HALF;
    end
  endtask : set_mode

  task automatic sel();
    begin
      ce_n = 1'b0;
      #HALF;
    end
  endtask : sel

  // select held until last bit done
  task automatic desel();
    begin
      sck = idle_lvl;
      #HALF;
      ce_n = 1'b1;
      // released line flips so stale data cannot pass
      si = ~si;
      #HALF;
    end
  endtask : desel

  // msb first, one byte each way
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    begin
      for (int i = 7; i >= 0; i--)
      begin
        sck = 1'b0;
        si = tx[i];
        #HALF;
        sck = 1'b1;
        // undriven output reads as pulled high
        rx[i] = so_oe ? so : 1'b1;
        #HALF;
      end
    end
  endtask : xfer

  task automatic hold(input logic v);
    begin
      hold_n = v;
      #HALF;
    end
  endtask : hold

  // clock and data wiggle while paused
  task automatic tog(input int n);
    begin
      repeat (n)
      begin
        sck = ~sck;
        si = ~si;
        #HALF;
      end
    end
  endtask : tog
endmodule : ssf_host_model

// File: ssf_pkg.sv
// constants shared by the serial flash front end
package ssf_pkg;

  // ********************
  // timing
  // ********************
  localparam int CLK_PERIOD_NS = 5;
  localparam int CHIP_ERASE_MS = 70;
  localparam int SECT_ERASE_MS = 18;
  localparam int PROG_US = 14;
  localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SECT_ERASE_CYC = SECT_ERASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_CYC = PROG_US * 1000 / CLK_PERIOD_NS;

  // ********************
  // bus register map
  // ********************
  localparam logic [7:0] REG_FILL_OFS = 8'h00;
  localparam logic [7:0] REG_STAT_OFS = 8'h04;
  localparam logic [7:0] REG_ADDR_OFS = 8'h08;
  localparam logic [7:0] REG_DATA_OFS = 8'h0c;
  localparam logic [7:0] FILL_RESET = 8'hff;

  // ********************
  // status register fields
  // ********************
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP0 = 2;
  localparam int ST_BP1 = 3;
  localparam int ST_AUTO_INC = 6;
  localparam int ST_LOCK = 7;
  localparam logic [1:0] BP_RESET = 2'h3;
  localparam int ST_HOLD = 8;
  localparam int ST_SEL = 9;

  // ********************
  // serial commands and layout
  // ********************
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_SECT = 8'h20;
  localparam logic [7:0] CMD_BLK = 8'h52;
  localparam logic [7:0] CMD_CHIP = 8'h60;
  localparam logic [7:0] CMD_RDID = 8'h90;
  localparam logic [23:0] SECT_MASK = 24'hfff000;
  localparam logic [23:0] BLK_MASK = 24'hff8000;
  localparam logic [2:0] BYTES_ADDR = 3'h3;
  localparam logic [2:0] BYTES_PROG = 3'h5;
  localparam logic [2:0] BYTES_MAX = 3'h7;
  // pin order sck, ce_n, si, hold_n, wp_n
  localparam logic [4:0] PIN_IDLE = 5'h0b;

  typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECT, OP_BLK, OP_CHIP} ssf_op_type;

endpackage : ssf_pkg

// File: ssf_top.sv
// serial flash slave front end with bus-side view registers
`timescale 1ns/1ps

// Behaviour
// - capture input bits on clock rise
// - shift output bits on clock fall
// - transaction starts on select falling edge
// - works in modes zero and three
// - commands, address, data via input only
// - pause suspends without losing state
// - protect pin gates lock bit
// - id read gives maker, device codes
// - four and thirty-two kilobyte erase units
// - chip erase busy seventy milliseconds
// - sector, block erase busy eighteen ms
// - byte program busy fourteen microseconds
// - pause enters, exits while clock low
// - paused: output released, inputs ignored
// - deselect during pause resets interface
// - status write refused when pin low, locked
module ssf_top
  import ssf_pkg::*;
#(
  parameter int CHIP_ERASE_CYCLES = CHIP_ERASE_CYC,
  parameter int SECT_ERASE_CYCLES = SECT_ERASE_CYC,
  parameter int CNT_W = 24,
  // identity codes are arbitrary
  parameter logic [7:0] MAKER_CODE = 8'ha5,
  parameter logic [7:0] DEVICE_CODE = 8'h3c
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // serial pins
  input wire logic SCK,
  input wire logic CE_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  input wire logic HOLD_N,
  input wire logic WP_N
);

  // ********************
  // checks and helpers
  // ********************
  if (CNT_W > 31 || CHIP_ERASE_CYCLES < 1 || SECT_ERASE_CYCLES < 1
      || CHIP_ERASE_CYCLES >= (1 << CNT_W) || SECT_ERASE_CYCLES >= (1 << CNT_W)
      || PROG_CYC >= (1 << CNT_W))
  begin : g_bad
    $error("busy counter too narrow");
  end

  function automatic logic [7:0] id_byte(input logic low_bit);
    id_byte = low_bit ? DEVICE_CODE : MAKER_CODE;
  endfunction : id_byte

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  // ********************
  // pin synchronisers
  // ********************
  logic [4:0] pin_m_ff;
  logic [4:0] pin_s_ff;
  logic sck_d_ff;
  logic ce_d_ff;
  logic sck_s;
  logic ce_n_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pin_m_ff <= PIN_IDLE;
      pin_s_ff <= PIN_IDLE;
      sck_d_ff <= 1'b0;
      ce_d_ff <= 1'b1;
    end
    else
    begin
      pin_m_ff <= {SCK, CE_N, SI, HOLD_N, WP_N};
      pin_s_ff <= pin_m_ff;
      sck_d_ff <= pin_s_ff[4];
      ce_d_ff <= pin_s_ff[3];
    end
  end

  assign sck_s = pin_s_ff[4];
  assign ce_n_s = pin_s_ff[3];
  assign si_s = pin_s_ff[2];
  assign hold_n_s = pin_s_ff[1];
  assign wp_n_s = pin_s_ff[0];

  // ********************
  // select and pause
  // ********************
  logic hold_ff;
  logic sel_ff;
  logic ce_fall;
  logic ce_rise;
  logic active;
  logic rise_ev;
  logic fall_ev;

  assign ce_fall = ce_d_ff & ~ce_n_s;
  assign ce_rise = ~ce_d_ff & ce_n_s;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      hold_ff <= 1'b0;
    else if (ce_n_s)
      hold_ff <= hold_ff & ~hold_n_s;
    else if (!sck_s)
      hold_ff <= ~hold_n_s;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      sel_ff <= 1'b0;
    else if (ce_n_s)
      sel_ff <= 1'b0;
    else if (ce_fall && !hold_ff)
      sel_ff <= 1'b1;
  end

  assign active = sel_ff & ~hold_ff & ~ce_n_s;
  assign rise_ev = active & sck_s & ~sck_d_ff;
  assign fall_ev = active & ~sck_s & sck_d_ff;

  // ********************
  // serial shift engine
  // ********************
  logic [7:0] in_sr_ff;
  logic [2:0] bit_cnt_ff;
  logic [2:0] byte_cnt_ff;
  logic [7:0] cmd_ff;
  logic [23:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] out_sr_ff;
  logic so_ff;
  logic oe_ff;
  logic byte_done;
  logic [7:0] new_byte;
  logic [7:0] cur_opc;
  logic [7:0] nxt_out;
  logic [7:0] status;
  logic busy_ff;
  logic wel_ff;
  logic [1:0] bp_ff;
  logic lock_ff;
  logic [7:0] fill_ff;

  assign byte_done = rise_ev && bit_cnt_ff == 3'h7;
  assign new_byte = {in_sr_ff[6:0], si_s};
  assign cur_opc = (byte_cnt_ff == 3'h0) ? new_byte : cmd_ff;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      in_sr_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
    end
    else if (!sel_ff)
    begin
      bit_cnt_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
    end
    else if (rise_ev)
    begin
      in_sr_ff <= new_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (byte_done && byte_cnt_ff != BYTES_MAX)
        byte_cnt_ff <= byte_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cmd_ff <= 8'h00;
      addr_ff <= 24'h000000;
      data_ff <= 8'h00;
    end
    else if (byte_done)
    begin
      case (byte_cnt_ff)
        3'h0: cmd_ff <= new_byte;
        3'h1, 3'h2, 3'h3: addr_ff <= {addr_ff[15:0], new_byte};
        3'h4:
        begin
          data_ff <= new_byte;
          if (cmd_ff == CMD_RDID)
            addr_ff <= {addr_ff[23:1], ~addr_ff[0]};
        end
        default:
          if (cmd_ff == CMD_RDID)
            addr_ff <= {addr_ff[23:1], ~addr_ff[0]};
      endcase
    end
  end

  always_comb
  begin
    nxt_out = 8'h00;
    if (cur_opc == CMD_RDSR)
      nxt_out = status;
    else if (cur_opc == CMD_RDID && byte_cnt_ff >= BYTES_ADDR)
      nxt_out = id_byte(byte_cnt_ff == BYTES_ADDR ? new_byte[0] : ~addr_ff[0]);
    else if (cur_opc == CMD_READ && byte_cnt_ff >= BYTES_ADDR && !busy_ff)
      nxt_out = fill_ff;
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      out_sr_ff <= 8'h00;
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      oe_ff <= active;
      if (!sel_ff)
        out_sr_ff <= 8'h00;
      else if (byte_done)
        out_sr_ff <= nxt_out;
      else if (fall_ev)
      begin
        so_ff <= out_sr_ff[7];
        out_sr_ff <= {out_sr_ff[6:0], 1'b0};
      end
    end
  end

  assign SO = so_ff;
  assign SO_OE = oe_ff;

  // ********************
  // command execution
  // ********************
  logic commit;
  logic go_stw;
  logic go_prog;
  logic go_sect;
  logic go_blk;
  logic go_chip;
  logic stw_ok;
  logic [CNT_W-1:0] busy_cnt_ff;
  logic [23:0] last_addr_ff;
  logic [7:0] last_data_ff;
  ssf_op_type last_op_ff;

  // executes on deselect at a byte boundary; aborted bytes do nothing
  assign commit = ce_rise & sel_ff & ~hold_ff & (bit_cnt_ff == 3'h0) & ~busy_ff;
  assign go_stw = commit && cmd_ff == CMD_STATUS_WRITE && byte_cnt_ff >= 3'h2;
  assign stw_ok = wp_n_s | ~lock_ff;
  assign go_prog = commit && wel_ff && cmd_ff == CMD_PROG && byte_cnt_ff >= BYTES_PROG;
  assign go_sect = commit && wel_ff && cmd_ff == CMD_SECT && byte_cnt_ff >= 3'h4;
  assign go_blk = commit && wel_ff && cmd_ff == CMD_BLK && byte_cnt_ff >= 3'h4;
  assign go_chip = commit && wel_ff && cmd_ff == CMD_CHIP && byte_cnt_ff >= 3'h1;

  assign status = {lock_ff, 1'b0, 2'h0, bp_ff, wel_ff, busy_ff};

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wel_ff <= 1'b0;
      bp_ff <= BP_RESET;
      lock_ff <= 1'b0;
    end
    else
    begin
      if (commit && cmd_ff == CMD_WREN && byte_cnt_ff >= 3'h1)
        wel_ff <= 1'b1;
      // empty frame must not replay a stale disable
      else if ((commit && cmd_ff == CMD_WRDI && byte_cnt_ff >= 3'h1)
          || (busy_ff && busy_cnt_ff == '0))
        wel_ff <= 1'b0;
      // status byte is the latest of the first three bytes after the command
      if (go_stw && stw_ok)
      begin
        bp_ff <= addr_ff[ST_BP1:ST_BP0];
        lock_ff <= addr_ff[ST_LOCK];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      busy_ff <= 1'b0;
      busy_cnt_ff <= '0;
    end
    else if (go_chip)
    begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= CNT_W'(CHIP_ERASE_CYCLES - 1);
    end
    else if (go_sect || go_blk)
    begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= CNT_W'(SECT_ERASE_CYCLES - 1);
    end
    else if (go_prog)
    begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= CNT_W'(PROG_CYC - 1);
    end
    else if (busy_ff)
    begin
      if (busy_cnt_ff == '0)
        busy_ff <= 1'b0;
      else
        busy_cnt_ff <= busy_cnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      last_addr_ff <= 24'h000000;
      last_data_ff <= 8'h00;
      last_op_ff <= OP_NONE;
    end
    else if (go_prog)
    begin
      last_addr_ff <= addr_ff;
      last_data_ff <= data_ff;
      last_op_ff <= OP_PROG;
    end
    else if (go_sect)
    begin
      last_addr_ff <= addr_ff & SECT_MASK;
      last_op_ff <= OP_SECT;
    end
    else if (go_blk)
    begin
      last_addr_ff <= addr_ff & BLK_MASK;
      last_op_ff <= OP_BLK;
    end
    else if (go_chip)
    begin
      last_addr_ff <= 24'h000000;
      last_op_ff <= OP_CHIP;
    end
  end

  // ********************
  // ahb-lite registers
  // ********************
  logic wr_ff;
  logic [7:0] wr_ofs_ff;
  logic [31:0] rdata_ff;
  logic ap_valid;

  // zero wait, always okay
  assign ap_valid = HSEL & HTRANS[1] & HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_ff;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      wr_ff <= 1'b0;
      wr_ofs_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
      fill_ff <= FILL_RESET;
    end
    else
    begin
      wr_ff <= ap_valid & HWRITE;
      wr_ofs_ff <= HADDR[7:0];
      if (wr_ff && wr_ofs_ff == REG_FILL_OFS)
        fill_ff <= HWDATA[7:0];
      if (ap_valid && !HWRITE)
      begin
        case (HADDR[7:0])
          REG_FILL_OFS: rdata_ff <= {24'h000000, fill_ff};
          REG_STAT_OFS: rdata_ff <= {22'h000000, sel_ff, hold_ff, status};
          REG_ADDR_OFS: rdata_ff <= {8'h00, last_addr_ff};
          REG_DATA_OFS: rdata_ff <= {21'h000000, last_op_ff, last_data_ff};
          default: rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // ********************
  // assertions
  // ********************
  sequence s_ce_start;
    ce_fall ##0 !hold_ff;
  endsequence

  sequence s_hold_desel;
    hold_ff ##0 ce_n_s;
  endsequence

  chk_rise_capture: assert property (rise_ev |=> in_sr_ff[0] == $past(si_s))
    else $error("input bit not captured on rise");
  chk_fall_shift: assert property (fall_ev |=> so_ff == $past(out_sr_ff[7]))
    else $error("output bit not driven on fall");
  chk_select_start: assert property (s_ce_start |=> sel_ff ##1 (sel_ff || ce_n_s))
    else $error("select fall did not start transaction");
  chk_hold_entry: assert property ($changed(hold_ff) && !ce_n_s |-> !$past(sck_s))
    else $error("pause changed while clock high");
  chk_hold_freeze: assert property (hold_ff && !ce_n_s |=> $stable(bit_cnt_ff)
      && $stable(cmd_ff) && $stable(out_sr_ff))
    else $error("state moved during pause");
  chk_hold_release: assert property (hold_ff |=> !SO_OE)
    else $error("output driven during pause");
  chk_hold_reset: assert property (s_hold_desel |=> !sel_ff ##1 byte_cnt_ff == 3'h0)
    else $error("deselect in pause kept interface");
  chk_lock_refuse: assert property (go_stw && !wp_n_s && lock_ff |=> $stable(bp_ff)
      && lock_ff)
    else $error("locked status write took effect");
  chk_id_code: assert property (byte_done && cur_opc == CMD_RDID
      && byte_cnt_ff == BYTES_ADDR |=> out_sr_ff == id_byte(addr_ff[0]))
    else $error("wrong id byte loaded");
  chk_chip_busy: assert property (go_chip |=> busy_ff
      && busy_cnt_ff == CNT_W'(CHIP_ERASE_CYCLES - 1))
    else $error("chip erase busy count wrong");
  chk_sect_busy: assert property (go_sect || go_blk |=> busy_ff
      && busy_cnt_ff == CNT_W'(SECT_ERASE_CYCLES - 1))
    else $error("erase busy count wrong");
  chk_prog_busy: assert property (go_prog |=> busy_ff[*8]
      ##0 busy_cnt_ff == CNT_W'(PROG_CYC - 8))
    else $error("program busy time wrong");
  chk_erase_align: assert property (go_sect |=> last_addr_ff[11:0] == 12'h000)
    else $error("sector address not aligned");

endmodule : ssf_top

// File: tb_spi_serial_flash_interface.sv
// self-checking bench for the serial flash front end
`timescale 1ns/1ps
module tb_spi_serial_flash_interface
  import ssf_pkg::*;
;
  // ********************
  // bench state
  // ********************
  localparam logic [7:0] ID_M = 8'h5a; // arbitrary
  localparam logic [7:0] ID_D = 8'hc3; // arbitrary
  logic core_clk, nrst, hsel, hwrite, wp_n, hresp, hreadyout;
  logic sck, ce_n, si, so, so_oe, hold_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  logic [7:0] r;
  int m_st, m_fill, miscompares, n_checks;

  ssf_top #(.CHIP_ERASE_CYCLES(50), .SECT_ERASE_CYCLES(50), .MAKER_CODE(ID_M),
    .DEVICE_CODE(ID_D)) dut (.CORE_CLK(core_clk), .NRST(nrst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .SCK(sck),
    .CE_N(ce_n), .SI(si), .SO(so), .SO_OE(so_oe), .HOLD_N(hold_n), .WP_N(wp_n));

  ssf_host_model host (.sck(sck), .ce_n(ce_n), .si(si), .hold_n(hold_n), .so(so),
    .so_oe(so_oe));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic close_out();
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        miscompares++;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    begin
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      @(posedge core_clk);
      while (hreadyout !== 1'b1)
        @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'b1)
        @(posedge core_clk);
      rd = hrdata;
    end
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
      chk({31'h0, hresp}, 32'h0);
    end
  endtask : rdchk

  task automatic spi(input int nrd);
    begin
      rx = {};
      host.sel();
      foreach (tx[i])
        host.xfer(tx[i], r);
      repeat (nrd)
      begin
        host.xfer(8'h00, r);
        rx.push_back(r);
      end
      host.desel();
    end
  endtask : spi

  task automatic rdsr_chk();
    begin
      tx = {CMD_RDSR};
      spi(2);
      chk(32'(rx[0]), 32'(m_st));
      chk(32'(rx[1]), 32'(m_st));
    end
  endtask : rdsr_chk

  task automatic test_id();
    begin
      rdchk(REG_STAT_OFS, 32'hffffffff, 32'h0c);
      rdchk(8'h10, 32'hffffffff, 32'h0);
      bus(1'b1, REG_STAT_OFS, 32'hff);
      rdchk(REG_STAT_OFS, 32'hff, 32'h0c);
      for (int m = 0; m < 2; m++)
      begin
        host.set_mode(m[0]);
        for (int a = 0; a < 2; a++)
        begin
          tx = {CMD_RDID, 8'h00, 8'h00, 8'(a)};
          spi(3);
          for (int k = 0; k < 3; k++)
            chk(32'(rx[k]), ((a + k) % 2) ? 32'(ID_D) : 32'(ID_M));
        end
      end
      rdchk(REG_FILL_OFS, 32'hffffffff, 32'hff);
      m_fill = $urandom % 256;
      bus(1'b1, REG_FILL_OFS, 32'(m_fill));
      host.set_mode(1'($urandom % 2));
      tx = {CMD_READ, 8'($urandom), 8'($urandom), 8'($urandom)};
      spi(2);
      chk(32'(rx[0]), 32'(m_fill));
      chk(32'(rx[1]), 32'(m_fill));
      $display("test id and read done");
    end
  endtask : test_id

  task automatic test_ops();
    logic [7:0] cmds[4];
    logic [23:0] masks[4];
    logic [23:0] a;
    logic [7:0] d;
    int cyc;
    begin
      cmds = '{CMD_PROG, CMD_SECT, CMD_BLK, CMD_CHIP};
      masks = '{24'hffffff, SECT_MASK, BLK_MASK, 24'h0};
      d = 8'($urandom);
      host.set_mode(1'b0);
      for (int i = 0; i < 4; i++)
      begin
        a = 24'($urandom);
        cyc = (i == 0) ? PROG_CYC : 50;
        tx = {CMD_WREN};
        spi(0);
        m_st = m_st | 2;
        rdsr_chk();
        tx = {cmds[i], a[23:16], a[15:8], a[7:0], d};
        if (i > 0)
          void'(tx.pop_back());
        if (i == 3)
          tx = {cmds[i]};
        spi(0);
        // busy from start for the full count
        rdchk(REG_STAT_OFS, 32'hff, 32'(m_st | 1));
        rdchk(REG_DATA_OFS, 32'h7ff, 32'((i + 1) << 8) | 32'(d));
        rdchk(REG_ADDR_OFS, 32'hffffffff, 32'(a & masks[i]));
        repeat (cyc - 40) @(posedge core_clk);
        rdchk(REG_STAT_OFS, 32'h1, 32'h1);
        repeat (60) @(posedge core_clk);
        m_st = m_st & 8'hfc;
        rdchk(REG_STAT_OFS, 32'hff, 32'(m_st));
      end
      // write disable clears the enable latch
      tx = {CMD_WREN};
      spi(0);
      tx = {CMD_WRDI};
      spi(0);
      rdsr_chk();
      $display("test program and erase done");
    end
  endtask : test_ops

  task automatic test_lock();
    logic wps[4];
    logic [7:0] vals[4];
    begin
      wps = '{1'b1, 1'b0, 1'b1, 1'b0};
      vals = '{8'h84, 8'h00, 8'h00, 8'h08};
      for (int i = 0; i < 4; i++)
      begin
        @(posedge core_clk);
        wp_n <= wps[i];
        repeat (4) @(posedge core_clk);
        // refused only with pin low and lock set
        if (wps[i] || !m_st[7])
          m_st = vals[i] & 8'h8c;
        tx = {CMD_STATUS_WRITE, vals[i]};
        spi(0);
        rdsr_chk();
      end
      @(posedge core_clk);
      wp_n <= 1'b1;
      $display("test lock done");
    end
  endtask : test_lock

  task automatic test_pause();
    begin
      host.set_mode(1'b0);
      host.sel();
      host.xfer(CMD_STATUS_WRITE, r);
      host.hold(1'b0);
      host.tog(5);
      rdchk(REG_STAT_OFS, 32'h3ff, 32'h300 | 32'(m_st));
      chk({31'h0, so_oe}, 32'h0);
      host.hold(1'b1);
      host.xfer(8'h88, r);
      host.desel();
      m_st = 8'h88;
      rdsr_chk();
      host.sel();
      host.xfer(CMD_WREN, r);
      host.hold(1'b0);
      host.tog(1);
      host.desel();
      rdchk(REG_STAT_OFS, 32'h2ff, 32'(m_st));
      host.hold(1'b1);
      rdsr_chk();
      $display("test pause done");
    end
  endtask : test_pause

  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwrite = 1'b0;
    hwdata = 32'h0;
    wp_n = 1'b1;
    miscompares = 0;
    n_checks = 0;
    m_st = 8'h0c;
    void'($urandom(95381));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    test_id();
    test_ops();
    test_lock();
    test_pause();
    close_out();
  end

  // watchdog well past the expected run length
  initial
  begin
    #400us;
    miscompares++;
    close_out();
  end
endmodule : tb_spi_serial_flash_interface
